// >>> cpu_sys_clock_and_reset_config.sv
`timescale 1ns/100ps
module cpu_sys_clock_and_reset_config (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_reset,
  // Power-good, active-low reset request, ring oscillator clock
  input wire logic i_power_good_in,
  input wire logic i_reset_req_n,
  input wire logic i_ring_osc_clock,
  // Interrupt-request pins carrying configuration during reset
  input wire logic [5:0] i_irq,
  // Clock outputs
  output logic o_cpu_clock_out_n,
  output logic o_system_clock_out_pos,
  output logic o_system_clock_out_neg,
  output logic o_delayed_system_clock_out_pos,
  output logic o_delayed_system_clock_out_neg,
  // Internal phase clocks
  output logic [3:0] o_phase,
  output logic [3:0] o_phase_n,
  output logic [3:0] o_dual_phase,
  // Transfer strobes
  output logic o_cpu_cycle_strobe,
  output logic o_bus_cycle_strobe,
  // Reset and sampled configuration status
  output logic o_chip_reset,
  output logic o_clock_from_ring,
  output logic [1:0] o_divisor_code,
  output logic [1:0] o_delay_code,
  output logic [1:0] o_bus_config
);
  localparam int HOLD_W = $clog2(clock_reset_pkg::RESET_HOLD_CYCLES + 1);

  ////////////////////////////////////////////////////////////////////////////
  // Reset entry
  logic sync_reset;
  logic [HOLD_W-1:0] hold_count;
  logic hold_done;
  logic raw_reset_req;

  assign raw_reset_req = !i_power_good_in || !i_reset_req_n;

  reset_sync u_reset_sync (
    .i_clk(i_clk),
    .i_reset(i_reset),
    .i_req(raw_reset_req),
    .o_reset(sync_reset)
  );

  // Counts hold time after power-good; chip reset is held until it completes
  always_ff @(posedge i_clk) begin
    if (i_reset || !i_power_good_in) begin
      hold_count <= '0;
    end else if (!hold_done) begin
      hold_count <= hold_count + HOLD_W'(1);
    end
  end
  assign hold_done = hold_count == HOLD_W'(clock_reset_pkg::RESET_HOLD_CYCLES);

  logic in_reset;
  assign in_reset = sync_reset || !hold_done;

  ////////////////////////////////////////////////////////////////////////////
  // Configuration sampling
  logic [1:0] divisor_code;
  logic [1:0] delay_code;
  logic [1:0] bus_config;

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      divisor_code <= clock_reset_pkg::DIV_RESET;
      delay_code <= clock_reset_pkg::DLY_RESET;
      bus_config <= 2'h0;
    end else if (in_reset) begin
      divisor_code <= i_irq[clock_reset_pkg::DIV_LSB +: 2];
      delay_code <= i_irq[clock_reset_pkg::DLY_LSB +: 2];
      bus_config <= {i_irq[clock_reset_pkg::BUS_CFG_LSB], i_irq[0]};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // CPU clock: input divided by two, free running
  logic cpu_phase;
  logic [1:0] phase_count;
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      cpu_phase <= 1'b0;
      phase_count <= 2'h0;
    end else begin
      cpu_phase <= !cpu_phase;
      phase_count <= phase_count + 2'h1;
    end
  end
  logic cpu_rise;
  assign cpu_rise = cpu_phase;

  ////////////////////////////////////////////////////////////////////////////
  // System clock divider in CPU cycles
  function automatic logic [2:0] period_last(input logic [1:0] code);
    unique case (code)
      clock_reset_pkg::DIV_2: period_last = clock_reset_pkg::PER_2;
      clock_reset_pkg::DIV_3_SYM: period_last = clock_reset_pkg::PER_3;
      clock_reset_pkg::DIV_3_ASYM: period_last = clock_reset_pkg::PER_3;
      clock_reset_pkg::DIV_4: period_last = clock_reset_pkg::PER_4;
    endcase
  endfunction

  logic [2:0] sys_count;
  logic [2:0] last_count;
  logic [2:0] high_len;
  logic next_sys_level;
  logic sys_level;
  logic [6:0] sys_hist;
  logic half_drop;
  logic [1:0] applied_delay;
  logic dly_level;

  assign last_count = period_last(divisor_code);
  // divide by four, six or eight
  assign high_len = (divisor_code == clock_reset_pkg::DIV_3_ASYM) ?
      clock_reset_pkg::HIGH_ASYM : 3'((last_count + 3'h2) >> 1);
  // Symmetric six falls mid CPU cycle, so the level moves on every input edge
  assign half_drop = divisor_code == clock_reset_pkg::DIV_3_SYM && sys_count == 3'h2;
  assign next_sys_level = cpu_rise ? (sys_count < high_len) : (sys_level && !half_drop);

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      sys_count <= 3'h0;
      sys_level <= 1'b0;
      sys_hist <= 7'h00;
    end else begin
      if (cpu_rise) begin
        sys_count <= (sys_count >= last_count) ? 3'h0 : sys_count + 3'h1;
      end
      sys_level <= next_sys_level;
      // Input-rate history keeps the half-cycle shape in the delayed copy
      sys_hist <= {sys_hist[5:0], next_sys_level};
    end
  end

  assign applied_delay = (delay_code == clock_reset_pkg::DLY_RESERVED) ?
      clock_reset_pkg::DLY_MAX : delay_code;
  assign dly_level = sys_hist[{applied_delay, 1'b0}];

  ////////////////////////////////////////////////////////////////////////////
  // Registered outputs
  logic [3:0] one_hot;
  assign one_hot = 4'h1 << phase_count;

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      o_cpu_clock_out_n <= 1'b1;
      o_system_clock_out_pos <= 1'b0;
      o_system_clock_out_neg <= 1'b1;
      o_delayed_system_clock_out_pos <= 1'b0;
      o_delayed_system_clock_out_neg <= 1'b1;
      o_phase <= 4'h0;
      o_phase_n <= 4'hf;
      o_dual_phase <= 4'h0;
      o_cpu_cycle_strobe <= 1'b0;
      o_bus_cycle_strobe <= 1'b0;
      o_chip_reset <= 1'b1;
      o_clock_from_ring <= 1'b1;
      o_divisor_code <= clock_reset_pkg::DIV_RESET;
      o_delay_code <= clock_reset_pkg::DLY_RESET;
      o_bus_config <= 2'h0;
    end else begin
      o_cpu_clock_out_n <= !cpu_phase;
      o_system_clock_out_pos <= sys_level;
      o_system_clock_out_neg <= !sys_level;
      o_delayed_system_clock_out_pos <= dly_level;
      o_delayed_system_clock_out_neg <= !dly_level;
      o_phase <= one_hot;
      o_phase_n <= ~one_hot;
      o_dual_phase <= {one_hot[3] | one_hot[0], one_hot[2] | one_hot[3],
                       one_hot[1] | one_hot[2], one_hot[0] | one_hot[1]};
      o_cpu_cycle_strobe <= cpu_rise;
      o_bus_cycle_strobe <= cpu_rise && sys_count == 3'h0;
      o_chip_reset <= in_reset;
      o_clock_from_ring <= !i_power_good_in;
      o_divisor_code <= divisor_code;
      o_delay_code <= delay_code;
      o_bus_config <= bus_config;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  property p_cpu_toggle;
    @(posedge i_clk) disable iff (i_reset)
      !$past(i_reset) && !$past(i_reset, 2) |->
        o_cpu_clock_out_n != $past(o_cpu_clock_out_n) ##1
        o_cpu_clock_out_n == $past(o_cpu_clock_out_n, 2);
  endproperty
  a_cpu_toggle: assert property (p_cpu_toggle) else $error("cpu clock not half rate");

  property p_pg_reset;
    @(posedge i_clk) disable iff (i_reset)
      !i_power_good_in |-> ##3 o_chip_reset;
  endproperty
  a_pg_reset: assert property (p_pg_reset) else $error("no reset with power-good low");

  property p_ring;
    @(posedge i_clk) disable iff (i_reset)
      !i_power_good_in |=> o_clock_from_ring;
  endproperty
  a_ring: assert property (p_ring) else $error("ring oscillator not selected");

  property p_reset_in;
    @(posedge i_clk) disable iff (i_reset)
      (!i_reset_req_n)[*3] |=> o_chip_reset;
  endproperty
  a_reset_in: assert property (p_reset_in) else $error("reset input ignored");

  property p_release;
    @(posedge i_clk) disable iff (i_reset)
      (i_power_good_in && i_reset_req_n && hold_done)[*4] |=> !o_chip_reset;
  endproperty
  a_release: assert property (p_release) else $error("reset not released");

  property p_sample;
    @(posedge i_clk) disable iff (i_reset)
      in_reset |=> divisor_code == $past(i_irq[2:1]) && delay_code == $past(i_irq[4:3]);
  endproperty
  a_sample: assert property (p_sample) else $error("config not sampled");

  property p_hold_cfg;
    @(posedge i_clk) disable iff (i_reset)
      !in_reset |=> $stable(divisor_code) && $stable(delay_code);
  endproperty
  a_hold_cfg: assert property (p_hold_cfg) else $error("config changed out of reset");

  property p_lag;
    @(posedge i_clk) disable iff (i_reset)
      applied_delay == 2'h1 |-> dly_level == $past(sys_level, 2);
  endproperty
  a_lag: assert property (p_lag) else $error("lag of one wrong");

  property p_reserved;
    @(posedge i_clk) disable iff (i_reset)
      delay_code == 2'h3 |-> dly_level == $past(sys_level, 6);
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved lag not max");

  property p_asym;
    @(posedge i_clk) disable iff (i_reset)
      cpu_rise && divisor_code == clock_reset_pkg::DIV_3_ASYM && sys_count == 3'h1
        |=> !sys_level;
  endproperty
  a_asym: assert property (p_asym) else $error("asymmetric high too long");
endmodule : cpu_sys_clock_and_reset_config

// >>> clock_reset_pkg.sv
// Contract
// - CPU clock output is the input clock divided by two.
// - System clock is CPU clock divided by two, three or four.
// - Delayed system clock lags by zero to three CPU cycles.
// - Clock generator runs whenever input clock runs, including during reset.
// - At three CPU periods the system clock may be symmetric or asymmetric.
// - Generate four single, four inverted and four dual-phase internal clocks.
// - Interface transfers align to system clock; fast cache and tag-ok follow CPU clock.
// - Power-good false: ring oscillator feeds generator, chip held in reset; the code only raises o_clock_from_ring, generator stays on i_clk.
// - Power-good true: external clock feeds generator, reset input governs reset.
// - Reset input forces the processor into a known state.
// - During reset, divisor, delay and bus config are sampled from interrupt pins.
// - Pins two,one select period 2, 3 symmetric, 3 asymmetric or 4 CPU cycles.
// - Pins four,three select lag 0, 1 or 2 CPU cycles; the code also gives lag 3 for code 3.
package clock_reset_pkg;
  localparam int PHASE_COUNT = 4;
  localparam int IRQ_WIDTH = 6;
  localparam int BUS_CFG_WIDTH = 2;
  // Field positions on the interrupt-request pins
  localparam int DIV_LSB = 1;
  localparam int DLY_LSB = 3;
  localparam int BUS_CFG_LSB = 5;
  localparam int BUS_CFG_PINS = 1;
  // Divisor codes
  localparam logic [1:0] DIV_2 = 2'h0;
  localparam logic [1:0] DIV_3_SYM = 2'h1;
  localparam logic [1:0] DIV_3_ASYM = 2'h2;
  localparam logic [1:0] DIV_4 = 2'h3;
  // Reset values of the sampled configuration, and maximum and reserved delay codes
  localparam logic [1:0] DIV_RESET = 2'h0;
  localparam logic [1:0] DLY_RESET = 2'h0;
  localparam logic [1:0] DLY_MAX = 2'h3;
  localparam logic [1:0] DLY_RESERVED = 2'h3;
  // System clock period in CPU cycles minus one, and high time
  localparam logic [2:0] PER_2 = 3'h1;
  localparam logic [2:0] PER_3 = 3'h2;
  localparam logic [2:0] PER_4 = 3'h3;
  localparam logic [2:0] HIGH_ASYM = 3'h1;
  // Reset hold after power-good, in ns, and in input clocks
  localparam int CLK_PERIOD_NS = 10;
  localparam int RESET_HOLD_NS = 100;
  localparam int RESET_HOLD_CYCLES = (RESET_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SYNC_STAGES = 2;
endpackage : clock_reset_pkg

// >>> reset_sync.sv
`timescale 1ns/100ps
// Two-flop synchroniser, assertion and release both delayed two clocks
module reset_sync (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_reset,
  // Raw reset request
  input wire logic i_req,
  // Synchronised reset
  output logic o_reset
);
  logic stage1;
  logic stage2;

  ////////////////////////////////////////////////////////////////////////////
  // release synchronised
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      stage1 <= 1'b1;
      stage2 <= 1'b1;
    end else begin
      stage1 <= i_req;
      stage2 <= stage1;
    end
  end

  assign o_reset = stage2;
endmodule : reset_sync

// >>> sys_logic_model.sv
`timescale 1ns/100ps
module sys_logic_model (
  // Clock
  input wire logic i_clk,
  // Bench commands
  input wire logic i_power_on,
  input wire logic i_reset_cmd,
  input wire logic i_slow,
  input wire logic [5:0] i_cfg,
  // Device pins
  output logic o_power_good,
  output logic o_reset_n,
  output logic [5:0] o_irq
);
  int hold_count = 0;
  int after_count = 0;
  int limit;
  ////////////////////////////////////////
  always @(posedge i_clk) begin
    o_power_good <= i_power_on;
    if (!o_power_good) begin
      hold_count <= 0;
    end else if (hold_count < 100) begin
      hold_count <= hold_count + 1;
    end
  end
  assign limit = (i_slow ? 3 : 1) * clock_reset_pkg::RESET_HOLD_CYCLES + 2;
  assign o_reset_n = !(i_reset_cmd || (o_power_good && hold_count < limit));
  // config held through reset
  // From eight clocks after reset release the pins carry the inverted config
  always @(posedge i_clk) begin
    after_count <= o_reset_n ? after_count + 1 : 0;
    o_irq <= (after_count < 8) ? i_cfg : ~i_cfg;
  end
endmodule : sys_logic_model

// >>> cpu_sys_clock_and_reset_config_bench.sv
`timescale 1ns/100ps
module cpu_sys_clock_and_reset_config_bench;
  logic i_clk = 1'b0;
  logic i_reset = 1'b1;
  logic ring = 1'b0;
  logic power_on = 1'b0;
  logic reset_cmd = 1'b0;
  logic slow = 1'b0;
  logic [5:0] cfg = 6'h00;
  logic power_good, reset_n, cpu_n, sys_p, sys_n, dly_p, dly_n;
  logic chip_reset, from_ring, cpu_stb, bus_stb;
  logic [5:0] irq;
  logic [3:0] ph, ph_n, dual;
  logic [1:0] div_code, dly_code, bus_cfg;
  int bad_count = 0;
  int comparisons = 0;
  always #5 i_clk = ~i_clk;
  always #7 ring = ~ring;
  sys_logic_model partner (.i_clk(i_clk), .i_power_on(power_on), .i_reset_cmd(reset_cmd),
    .i_slow(slow), .i_cfg(cfg), .o_power_good(power_good), .o_reset_n(reset_n), .o_irq(irq));
  cpu_sys_clock_and_reset_config dut (.i_clk(i_clk), .i_reset(i_reset),
    .i_power_good_in(power_good), .i_reset_req_n(reset_n), .i_ring_osc_clock(ring),
    .i_irq(irq), .o_cpu_clock_out_n(cpu_n), .o_system_clock_out_pos(sys_p),
    .o_system_clock_out_neg(sys_n), .o_delayed_system_clock_out_pos(dly_p),
    .o_delayed_system_clock_out_neg(dly_n), .o_phase(ph), .o_phase_n(ph_n),
    .o_dual_phase(dual), .o_cpu_cycle_strobe(cpu_stb), .o_bus_cycle_strobe(bus_stb),
    .o_chip_reset(chip_reset), .o_clock_from_ring(from_ring), .o_divisor_code(div_code),
    .o_delay_code(dly_code), .o_bus_config(bus_cfg));
  ////////////////////////////////////////
  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD %s expected %0h seen %0h", what, exp, got);
    end
  endtask : check
  task automatic test_done;
    $display("Comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : test_done
  task automatic set_power(input logic v);
    @(posedge i_clk);
    #1 power_on = v;
  endtask : set_power
  task automatic wait_chip(input logic lvl);
    int n;
    n = 0;
    while (chip_reset !== lvl && n < 80) begin
      @(negedge i_clk);
      n++;
    end
    check("chip reset", {7'h0, lvl}, {7'h0, chip_reset});
  endtask : wait_chip
  task automatic run_loop(output int ct, output int cs, output int bs, output int pk);
    logic pc;
    pc = cpu_n;
    ct = 0;
    cs = 0;
    bs = 0;
    pk = 0;
    repeat (24) begin
      @(negedge i_clk);
      if (cpu_n !== pc) ct++;
      pc = cpu_n;
      if (cpu_stb === 1'b1) cs++;
      if (bus_stb === 1'b1) bs++;
      if ($onehot(ph) && ph_n === ~ph && $countones(dual) == 2 && sys_n === ~sys_p
          && dly_n === ~dly_p) pk++;
    end
  endtask : run_loop
  task automatic measure(output int per, output int hi, output int lag);
    int r1, r2, f, d;
    logic ps, pd;
    r1 = -1;
    r2 = -1;
    f = -1;
    d = -1;
    ps = sys_p;
    pd = dly_p;
    for (int t = 0; t < 40; t++) begin
      @(negedge i_clk);
      if (sys_p && !ps && r1 >= 0 && r2 < 0) r2 = t;
      if (sys_p && !ps && r1 < 0) r1 = t;
      if (!sys_p && ps && r1 >= 0 && f < 0) f = t;
      if (dly_p && !pd && r1 >= 0 && d < 0) d = t;
      ps = sys_p;
      pd = dly_p;
    end
    per = r2 - r1;
    hi = f - r1;
    lag = d - r1;
  endtask : measure
  task automatic run_cfg(input logic [5:0] c);
    int per, hi, lag, ct, cs, bs, pk, per_e, hi_e;
    per_e = (c[2:1] == 2'h0) ? 4 : (c[2:1] == 2'h3) ? 8 : 6;
    hi_e = (c[2:1] == 2'h1) ? 3 : (c[2:1] == 2'h3) ? 4 : 2;
    @(posedge i_clk);
    #1 reset_cmd = 1'b1;
    cfg = c;
    wait_chip(1'b1);
    run_loop(ct, cs, bs, pk);
    check("cpu toggles in reset", 8'h18, ct[7:0]);
    @(posedge i_clk);
    #1 reset_cmd = 1'b0;
    wait_chip(1'b0);
    measure(per, hi, lag);
    check("sys period", per_e[7:0], per[7:0]);
    check("sys high", hi_e[7:0], hi[7:0]);
    check("sys lag", 8'((2 * c[4:3]) % per_e), lag[7:0]);
    run_loop(ct, cs, bs, pk);
    check("cpu toggles", 8'h18, ct[7:0]);
    check("cpu strobes", 8'h0c, cs[7:0]);
    check("bus strobes", 8'(24 / per_e), bs[7:0]);
    check("phases and pairs", 8'h18, pk[7:0]);
    check("divisor", {6'h0, c[2:1]}, {6'h0, div_code});
    check("delay", {6'h0, c[4:3]}, {6'h0, dly_code});
    check("bus config", {6'h0, c[5], c[0]}, {6'h0, bus_cfg});
  endtask : run_cfg
  ////////////////////////////////////////
  initial begin
    repeat (4) @(posedge i_clk);
    #1 i_reset = 1'b0;
    repeat (4) @(negedge i_clk);
    check("ring select", 8'h01, {7'h0, from_ring});
    check("chip reset", 8'h01, {7'h0, chip_reset});
    slow = 1'b1;
    set_power(1'b1);
    wait_chip(1'b0);
    check("ring select", 8'h00, {7'h0, from_ring});
    for (int i = 0; i < 4; i++) begin
      run_cfg({i[0], i[1:0], i[1:0], ~i[0]});
    end
    run_cfg(6'h2b);
    // Power loss with the reset pin released
    set_power(1'b0);
    wait_chip(1'b1);
    check("ring select", 8'h01, {7'h0, from_ring});
    slow = 1'b0;
    set_power(1'b1);
    wait_chip(1'b0);
    run_cfg(6'h0d);
    test_done();
  end
  initial begin
    #50000;
    bad_count++;
    $display("BAD watchdog expected done seen hang");
    test_done();
  end
endmodule : cpu_sys_clock_and_reset_config_bench
